// ---- hic_pkg.sv ----
package hic_pkg;

    // Register indices; byte address is four times the index
    localparam logic [9:0] HIC_IDX_ARB = 10'h005;
    localparam logic [9:0] HIC_IDX_TXN = 10'h006;
    localparam logic [9:0] HIC_IDX_TXN2 = 10'h007;
    localparam logic [9:0] HIC_IDX_PRIO = 10'h00C;
    localparam logic [9:0] HIC_IDX_PWRDET = 10'h017;
    localparam logic [9:0] HIC_IDX_RECOV = 10'h01C;
    localparam logic [9:0] HIC_IDX_PCHECK = 10'h01E;
    localparam logic [9:0] HIC_IDX_LPWR = 10'h023;
    localparam logic [9:0] HIC_IDX_LWA = 10'h02D;
    localparam logic [9:0] HIC_IDX_STATUS = 10'h030;
    localparam logic [9:0] HIC_IDX_CLUMP = 10'h05C;
    localparam logic [9:0] HIC_IDX_LCTL = 10'h0C8;

    // Field positions
    localparam int HIC_RECOV_HOLD = 17;
    localparam int HIC_TXN_ORDER = 0;
    localparam int HIC_TXN_STREAM = 1;
    localparam int HIC_TXN_EXTWB = 9;
    localparam int HIC_TXN_RSPBUF = 13;
    localparam int HIC_TXN_PWRLO = 15;
    localparam int HIC_TXN_PWRHI = 16;
    localparam int HIC_TXN_SPRD = 17;
    localparam int HIC_TXN_DISPBYP = 25;
    localparam int HIC_TXN_TAGFIX = 30;
    localparam int HIC_TXN2_BYTEOPT = 0;
    localparam int HIC_TXN2_STPDLY = 1;
    localparam int HIC_TXN2_SMMDLY = 2;
    localparam int HIC_TXN2_DROPZ = 15;
    localparam int HIC_PRIO_1A = 0;
    localparam int HIC_PRIO_1B = 2;
    localparam int HIC_PRIO_MC = 4;
    localparam int HIC_LPWR_TXRST = 28;
    localparam int HIC_LWA_WCOMB = 4;
    localparam int HIC_LWA_DLL = 6;
    localparam int HIC_ARB_WRR = 2;
    localparam int HIC_ARB_WACK = 9;
    localparam int HIC_ARB_TDONE = 10;
    localparam int HIC_PWRDET_C3 = 30;
    localparam int HIC_CLUMP_23 = 3;
    localparam int HIC_CLUMP_F10 = 16;
    localparam int HIC_CLUMP_1112 = 18;
    localparam int HIC_LCTL_ISOC = 12;

    // Field values and reset values
    localparam logic [1:0] HIC_PWR_DECODE_ON = 2'h3;
    localparam logic [31:0] HIC_REG_RESET = 32'h0000_0000;
    localparam logic [2:0] HIC_CLUMP_RESET = 3'h0;

    // AXI responses
    localparam logic [1:0] HIC_RESP_OKAY = 2'h0;
    localparam logic [1:0] HIC_RESP_SLVERR = 2'h2;

endpackage : hic_pkg

// ---- hic_link_config.sv ----
`timescale 1ns/10ps
module hic_link_config (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic link_stop_request,
    input wire logic link_recovery,
    input wire logic link_disconnect,
    input wire logic ls1_mode,
    input wire logic link_retrain,
    input wire logic gsm_dma_seen,
    input wire logic c3_state,
    input wire logic warm_reset,
    output logic link_stop_allow,
    output logic write_pass_read_en,
    output logic cpu_write_stream_en,
    output logic ext_write_buffer_en,
    output logic extra_rsp_buffer_en,
    output logic special_read_pass_en,
    output logic power_cycle_decode_en,
    output logic display_handshake_bypass,
    output logic tag_fix_en,
    output logic io_byte_write_opt_en,
    output logic drop_zero_mask_en,
    output logic stop_clock_delay_en,
    output logic upstream_smm_delay_en,
    output logic [1:0] stage1a_priority,
    output logic [1:0] stage1b_priority,
    output logic [1:0] memory_client_priority,
    output logic link_tx_reset,
    output logic link_dll_reset,
    output logic write_combine_wa_en,
    output logic rw_wrr_en,
    output logic [31:0] protocol_check_en,
    output logic write_ack_fifo_wa_en,
    output logic target_done_wa_en,
    output logic gsm_dma_detect,
    output logic [2:0] unit_id_clump,
    output logic isochronous_flow_mode
);

    // Byte-lane merge for every writable word
    function automatic logic [31:0] hic_merge(input logic [31:0] old_word,
                                              input logic [31:0] new_word,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old_word;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_word[8*b +: 8];
            end
        end
        return res;
    endfunction : hic_merge

    // Word index from a byte address
    function automatic logic [9:0] hic_index(input logic [11:0] addr);
        return addr[11:2];
    endfunction : hic_index

    logic [31:0] arb_r, txn_r, txn2_r, prio_r, pwrdet_r, recov_r;
    logic [31:0] pcheck_r, lpwr_r, lwa_r;
    logic [2:0] clump_r;
    logic lctl_isoc_r;
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic aw_got_r, w_got_r;
    logic disc_q_r, retrain_q_r;
    logic do_write;
    logic [9:0] wr_idx;
    logic wr_hit;
    logic [31:0] rd_word;
    logic rd_hit;
    logic [31:0] clump_word, lctl_word, clump_merged, lctl_merged;

    assign do_write = aw_got_r && w_got_r && !s_axi_bvalid;
    assign wr_idx = hic_index(awaddr_r);

    // Sparse words laid out at their bit positions, shared by write merge and read mux
    assign clump_word = {13'h0000, clump_r[2], 1'b0, clump_r[1], 12'h000, clump_r[0], 3'h0};
    assign lctl_word = {19'h00000, lctl_isoc_r, 12'h000};
    assign clump_merged = hic_merge(clump_word, wdata_r, wstrb_r);
    assign lctl_merged = hic_merge(lctl_word, wdata_r, wstrb_r);

    // Address and data are taken independently, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            aw_got_r <= 1'b0;
            awaddr_r <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_got_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
            aw_got_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b1;
            w_got_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
            w_got_r <= 1'b0;
        end
    end

    // Write decode; unmapped and status words answer SLVERR
    always_comb begin
        unique case (wr_idx)
            hic_pkg::HIC_IDX_ARB, hic_pkg::HIC_IDX_TXN, hic_pkg::HIC_IDX_TXN2,
            hic_pkg::HIC_IDX_PRIO, hic_pkg::HIC_IDX_PWRDET, hic_pkg::HIC_IDX_RECOV,
            hic_pkg::HIC_IDX_PCHECK, hic_pkg::HIC_IDX_LPWR, hic_pkg::HIC_IDX_LWA,
            hic_pkg::HIC_IDX_CLUMP, hic_pkg::HIC_IDX_LCTL: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= hic_pkg::HIC_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? hic_pkg::HIC_RESP_OKAY : hic_pkg::HIC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Plain control words, byte-lane merged
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arb_r <= hic_pkg::HIC_REG_RESET;
            txn_r <= hic_pkg::HIC_REG_RESET;
            txn2_r <= hic_pkg::HIC_REG_RESET;
            prio_r <= hic_pkg::HIC_REG_RESET;
            pwrdet_r <= hic_pkg::HIC_REG_RESET;
            recov_r <= hic_pkg::HIC_REG_RESET;
            pcheck_r <= hic_pkg::HIC_REG_RESET;
            lpwr_r <= hic_pkg::HIC_REG_RESET;
            lwa_r <= hic_pkg::HIC_REG_RESET;
        end else if (do_write) begin
            unique case (wr_idx)
                hic_pkg::HIC_IDX_ARB: arb_r <= hic_merge(arb_r, wdata_r, wstrb_r);
                hic_pkg::HIC_IDX_TXN: txn_r <= hic_merge(txn_r, wdata_r, wstrb_r);
                hic_pkg::HIC_IDX_TXN2: txn2_r <= hic_merge(txn2_r, wdata_r, wstrb_r);
                hic_pkg::HIC_IDX_PRIO: prio_r <= hic_merge(prio_r, wdata_r, wstrb_r);
                hic_pkg::HIC_IDX_PWRDET: pwrdet_r <= hic_merge(pwrdet_r, wdata_r, wstrb_r);
                hic_pkg::HIC_IDX_RECOV: recov_r <= hic_merge(recov_r, wdata_r, wstrb_r);
                hic_pkg::HIC_IDX_PCHECK: pcheck_r <= hic_merge(pcheck_r, wdata_r, wstrb_r);
                hic_pkg::HIC_IDX_LPWR: lpwr_r <= hic_merge(lpwr_r, wdata_r, wstrb_r);
                hic_pkg::HIC_IDX_LWA: lwa_r <= hic_merge(lwa_r, wdata_r, wstrb_r);
                default: ;
            endcase
        end
    end

    // Clumping: live at once, wiped by warm reset which wins over a write
    always_ff @(posedge aclk) begin
        if (!aresetn || warm_reset) begin
            clump_r <= hic_pkg::HIC_CLUMP_RESET;
        end else if (do_write && wr_idx == hic_pkg::HIC_IDX_CLUMP) begin
            clump_r <= {clump_merged[hic_pkg::HIC_CLUMP_1112],
                        clump_merged[hic_pkg::HIC_CLUMP_F10],
                        clump_merged[hic_pkg::HIC_CLUMP_23]};
        end
    end

    // Isochronous enable is staged; the live mode loads only at warm reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lctl_isoc_r <= 1'b0;
            isochronous_flow_mode <= 1'b0;
        end else begin
            if (do_write && wr_idx == hic_pkg::HIC_IDX_LCTL) begin
                lctl_isoc_r <= lctl_merged[hic_pkg::HIC_LCTL_ISOC];
            end
            if (warm_reset) begin
                isochronous_flow_mode <= lctl_isoc_r;
            end
        end
    end

    // Read mux; status word shows live state
    always_comb begin
        rd_hit = 1'b1;
        unique case (hic_index(s_axi_araddr))
            hic_pkg::HIC_IDX_ARB: rd_word = arb_r;
            hic_pkg::HIC_IDX_TXN: rd_word = txn_r;
            hic_pkg::HIC_IDX_TXN2: rd_word = txn2_r;
            hic_pkg::HIC_IDX_PRIO: rd_word = prio_r;
            hic_pkg::HIC_IDX_PWRDET: rd_word = pwrdet_r;
            hic_pkg::HIC_IDX_RECOV: rd_word = recov_r;
            hic_pkg::HIC_IDX_PCHECK: rd_word = pcheck_r;
            hic_pkg::HIC_IDX_LPWR: rd_word = lpwr_r;
            hic_pkg::HIC_IDX_LWA: rd_word = lwa_r;
            hic_pkg::HIC_IDX_CLUMP: rd_word = clump_word;
            hic_pkg::HIC_IDX_LCTL: rd_word = lctl_word;
            hic_pkg::HIC_IDX_STATUS: rd_word = {29'h00000000, isochronous_flow_mode,
                                                link_stop_allow, link_recovery};
            default: begin
                rd_word = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // One read at a time; data captured as the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= hic_pkg::HIC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? hic_pkg::HIC_RESP_OKAY : hic_pkg::HIC_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
        end
    end

    // Link events: disconnect exit and retrain edges
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            disc_q_r <= 1'b0;
            retrain_q_r <= 1'b0;
            link_tx_reset <= 1'b0;
            link_dll_reset <= 1'b0;
        end else begin
            disc_q_r <= link_disconnect;
            retrain_q_r <= link_retrain;
            link_tx_reset <= lpwr_r[hic_pkg::HIC_LPWR_TXRST] && ls1_mode
                             && disc_q_r && !link_disconnect;
            link_dll_reset <= lwa_r[hic_pkg::HIC_LWA_DLL] && link_retrain
                              && !retrain_q_r;
        end
    end

    // Gating of stop-allow and shared-memory DMA detection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link_stop_allow <= 1'b0;
            gsm_dma_detect <= 1'b0;
        end else begin
            link_stop_allow <= link_stop_request
                && !(recov_r[hic_pkg::HIC_RECOV_HOLD] && link_recovery);
            gsm_dma_detect <= gsm_dma_seen
                && (!pwrdet_r[hic_pkg::HIC_PWRDET_C3] || c3_state);
        end
    end

    // Control outputs drawn from the words; one cycle behind a write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            write_pass_read_en <= 1'b1;
            cpu_write_stream_en <= 1'b0;
            ext_write_buffer_en <= 1'b0;
            extra_rsp_buffer_en <= 1'b0;
            special_read_pass_en <= 1'b0;
            power_cycle_decode_en <= 1'b0;
            display_handshake_bypass <= 1'b0;
            tag_fix_en <= 1'b0;
            io_byte_write_opt_en <= 1'b0;
            drop_zero_mask_en <= 1'b0;
            stop_clock_delay_en <= 1'b0;
            upstream_smm_delay_en <= 1'b0;
            stage1a_priority <= 2'h0;
            stage1b_priority <= 2'h0;
            memory_client_priority <= 2'h0;
            write_combine_wa_en <= 1'b0;
            rw_wrr_en <= 1'b0;
            protocol_check_en <= 32'h0000_0000;
            write_ack_fifo_wa_en <= 1'b0;
            target_done_wa_en <= 1'b0;
            unit_id_clump <= 3'h0;
        end else begin
            write_pass_read_en <= !txn_r[hic_pkg::HIC_TXN_ORDER];
            cpu_write_stream_en <= txn_r[hic_pkg::HIC_TXN_STREAM];
            ext_write_buffer_en <= txn_r[hic_pkg::HIC_TXN_EXTWB];
            extra_rsp_buffer_en <= txn_r[hic_pkg::HIC_TXN_RSPBUF];
            special_read_pass_en <= txn_r[hic_pkg::HIC_TXN_SPRD];
            power_cycle_decode_en <= txn_r[hic_pkg::HIC_TXN_PWRHI:hic_pkg::HIC_TXN_PWRLO]
                                     == hic_pkg::HIC_PWR_DECODE_ON;
            display_handshake_bypass <= txn_r[hic_pkg::HIC_TXN_DISPBYP];
            tag_fix_en <= txn_r[hic_pkg::HIC_TXN_TAGFIX];
            io_byte_write_opt_en <= txn2_r[hic_pkg::HIC_TXN2_BYTEOPT];
            drop_zero_mask_en <= txn2_r[hic_pkg::HIC_TXN2_DROPZ];
            stop_clock_delay_en <= txn2_r[hic_pkg::HIC_TXN2_STPDLY];
            upstream_smm_delay_en <= txn2_r[hic_pkg::HIC_TXN2_SMMDLY];
            stage1a_priority <= prio_r[hic_pkg::HIC_PRIO_1A +: 2];
            stage1b_priority <= prio_r[hic_pkg::HIC_PRIO_1B +: 2];
            memory_client_priority <= prio_r[hic_pkg::HIC_PRIO_MC +: 2];
            write_combine_wa_en <= lwa_r[hic_pkg::HIC_LWA_WCOMB];
            rw_wrr_en <= arb_r[hic_pkg::HIC_ARB_WRR];
            protocol_check_en <= pcheck_r;
            write_ack_fifo_wa_en <= arb_r[hic_pkg::HIC_ARB_WACK];
            target_done_wa_en <= arb_r[hic_pkg::HIC_ARB_TDONE];
            unit_id_clump <= warm_reset ? 3'h0 : clump_r;
        end
    end

    default clocking hic_cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_STOP_HOLD: assert property (
        (recov_r[hic_pkg::HIC_RECOV_HOLD] && link_recovery) |=> !link_stop_allow)
        else $error("stop-allow raised during held recovery");
    AST_WRITE_PASS: assert property (
        $changed(txn_r) |-> ##2 (write_pass_read_en == !txn_r[hic_pkg::HIC_TXN_ORDER]))
        else $error("write-pass enable does not follow bit 0");
    AST_PWR_DECODE: assert property (
        (txn_r[hic_pkg::HIC_TXN_PWRHI:hic_pkg::HIC_TXN_PWRLO] != hic_pkg::HIC_PWR_DECODE_ON)
        |=> !power_cycle_decode_en)
        else $error("power cycle decode on without value 3");
    AST_MC_PRIO: assert property (
        $stable(prio_r) [*2] |-> memory_client_priority == prio_r[hic_pkg::HIC_PRIO_MC +: 2])
        else $error("memory client priority mismatch");
    AST_TX_RESET: assert property (
        (lpwr_r[hic_pkg::HIC_LPWR_TXRST] && ls1_mode && $fell(link_disconnect))
        |=> link_tx_reset ##1 !link_tx_reset || $fell(link_disconnect))
        else $error("transmitter reset missing on disconnect exit");
    AST_DLL_RESET: assert property (
        (!lwa_r[hic_pkg::HIC_LWA_DLL]) |=> !link_dll_reset)
        else $error("DLL reset without enable");
    AST_PCHECK: assert property (
        ##1 protocol_check_en == $past(pcheck_r))
        else $error("protocol check mask lags");
    AST_GSM_C3: assert property (
        (pwrdet_r[hic_pkg::HIC_PWRDET_C3] && !c3_state) |=> !gsm_dma_detect)
        else $error("shared-memory DMA detected outside C3");
    AST_CLUMP_WARM: assert property (
        warm_reset |=> (clump_r == 3'h0 && unit_id_clump == 3'h0))
        else $error("clumping survived warm reset");
    AST_ISOC_STAGED: assert property (
        !warm_reset |=> $stable(isochronous_flow_mode))
        else $error("isochronous mode changed without warm reset");
    AST_WRITE_RESP: assert property (
        (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) |-> ##2 s_axi_bvalid)
        else $error("write response late");

    COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
    COV_CLUMP: cover property (clump_r != 3'h0 ##1 warm_reset);
    COV_HOLD: cover property (recov_r[hic_pkg::HIC_RECOV_HOLD] && link_recovery
                              && link_stop_request);
    COV_ISOC: cover property ($rose(isochronous_flow_mode));

endmodule : hic_link_config

// ---- hic_link_partner.sv ----
`timescale 1ns/10ps
// Processor end of the link: the status lines the block watches, plus its own mode
module hic_link_partner (
    input wire logic aclk,
    input wire logic isochronous_flow_mode,
    output logic link_stop_request,
    output logic link_recovery,
    output logic link_disconnect,
    output logic ls1_mode,
    output logic link_retrain,
    output logic gsm_dma_seen,
    output logic c3_state
);
    logic [6:0] state_r = 7'h00;
    logic display_refresh_r;
    // One word, so the block never sees a half-updated status
    assign {link_stop_request, link_recovery, link_disconnect, ls1_mode, link_retrain,
            gsm_dma_seen, c3_state} = state_r;
    // Legacy refresh stands in whenever the flow mode is off
    always_ff @(posedge aclk) begin
        display_refresh_r <= !isochronous_flow_mode;
    end
    // Changes land just after an edge
    task automatic drive(input logic [6:0] v);
        @(posedge aclk);
        state_r <= v;
    endtask : drive
endmodule : hic_link_partner

// ---- hic_link_config_tb.sv ----
`timescale 1ns/10ps
module hic_link_config_tb;
    logic aclk = 1'b0, aresetn = 1'b0, warm_reset = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, protocol_check_en, cfg_w;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, stage1a_priority, stage1b_priority;
    logic [1:0] memory_client_priority;
    logic [2:0] unit_id_clump;
    logic link_stop_request, link_recovery, link_disconnect, ls1_mode, link_retrain;
    logic gsm_dma_seen, c3_state, link_stop_allow, write_pass_read_en, cpu_write_stream_en;
    logic ext_write_buffer_en, extra_rsp_buffer_en, special_read_pass_en, tag_fix_en;
    logic power_cycle_decode_en, display_handshake_bypass, io_byte_write_opt_en;
    logic drop_zero_mask_en, stop_clock_delay_en, upstream_smm_delay_en, link_tx_reset;
    logic link_dll_reset, write_combine_wa_en, rw_wrr_en, write_ack_fifo_wa_en;
    logic target_done_wa_en, gsm_dma_detect, isochronous_flow_mode;
    int num_errors = 0, num_checks = 0;
    // Config outputs packed once so groups compare as slices
    assign cfg_w = {2'b00, unit_id_clump, memory_client_priority, stage1b_priority,
        stage1a_priority, write_pass_read_en, cpu_write_stream_en, ext_write_buffer_en,
        extra_rsp_buffer_en, special_read_pass_en, power_cycle_decode_en,
        display_handshake_bypass, tag_fix_en, io_byte_write_opt_en, stop_clock_delay_en,
        upstream_smm_delay_en, drop_zero_mask_en, write_combine_wa_en, rw_wrr_en,
        write_ack_fifo_wa_en, target_done_wa_en, isochronous_flow_mode, gsm_dma_detect,
        link_stop_allow, link_tx_reset, link_dll_reset};
    hic_link_config hic_link_config_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .link_stop_request, .link_recovery, .link_disconnect, .ls1_mode, .link_retrain,
        .gsm_dma_seen, .c3_state, .warm_reset, .link_stop_allow, .write_pass_read_en,
        .cpu_write_stream_en, .ext_write_buffer_en, .extra_rsp_buffer_en,
        .special_read_pass_en, .power_cycle_decode_en, .display_handshake_bypass,
        .tag_fix_en, .io_byte_write_opt_en, .drop_zero_mask_en, .stop_clock_delay_en,
        .upstream_smm_delay_en, .stage1a_priority, .stage1b_priority,
        .memory_client_priority, .link_tx_reset, .link_dll_reset, .write_combine_wa_en,
        .rw_wrr_en, .protocol_check_en, .write_ack_fifo_wa_en, .target_done_wa_en,
        .gsm_dma_detect, .unit_id_clump, .isochronous_flow_mode);
    hic_link_partner hic_link_partner_i (.aclk, .isochronous_flow_mode, .link_stop_request,
        .link_recovery, .link_disconnect, .ls1_mode, .link_retrain, .gsm_dma_seen,
        .c3_state);
    // 250 MHz
    initial begin
        forever #2 aclk = ~aclk;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask : tick
    // Address and data offered together, each dropped once its own ready is seen
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", er, s_axi_bresp);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk("rdata", e, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
    endtask : rd
    // Count pulses over a short window after a status change
    task automatic pulses(input logic [6:0] v, input int et, input int ed);
        logic [31:0] nt, nd;
        nt = 32'h0000_0000;
        nd = 32'h0000_0000;
        hic_link_partner_i.drive(v);
        repeat (4) begin
            tick(1);
            nt = nt + {31'h00000000, link_tx_reset};
            nd = nd + {31'h00000000, link_dll_reset};
        end
        chk("tx_pulses", et, nt);
        chk("dll_pulses", ed, nd);
    endtask : pulses
    task automatic t_reset;
        tick(1);
        chk("cfg_reset", 32'h0010_0000, cfg_w);
        rd(12'h018, 32'h0000_0000, 2'h0);
        rd(12'h004, 32'h0000_0000, 2'h2);
        wr(12'h004, 32'hFFFF_FFFF, 4'hF, 2'h2);
        wr(12'h0C0, 32'hFFFF_FFFF, 4'hF, 2'h2);
    endtask : t_reset
    task automatic t_txn;
        wr(12'h018, 32'h4203_A202, 4'hF, 2'h0);
        tick(1);
        chk("txn_out", 8'hFF, cfg_w[20:13]);
        wr(12'h018, 32'h0000_0001, 4'h1, 2'h0);
        tick(1);
        chk("txn_order", 8'h3F, cfg_w[20:13]);
        rd(12'h018, 32'h4203_A201, 2'h0);
        wr(12'h018, 32'h0000_0000, 4'h2, 2'h0);
        tick(1);
        chk("txn_lane1", 8'h0B, cfg_w[20:13]);
    endtask : t_txn
    task automatic t_misc;
        wr(12'h01C, 32'h0000_8007, 4'hF, 2'h0);
        wr(12'h030, 32'h0000_0039, 4'hF, 2'h0);
        wr(12'h0B4, 32'h0000_0050, 4'hF, 2'h0);
        wr(12'h014, 32'h0000_0604, 4'hF, 2'h0);
        wr(12'h078, 32'hFFFF_FFFF, 4'hF, 2'h0);
        tick(1);
        chk("txn2_out", 4'hF, cfg_w[12:9]);
        chk("prio_out", 6'h39, cfg_w[26:21]);
        chk("wa_out", 4'hF, cfg_w[8:5]);
        chk("pcheck", 32'hFFFF_FFFF, protocol_check_en);
        rd(12'h030, 32'h0000_0039, 2'h0);
    endtask : t_misc
    task automatic t_link;
        wr(12'h070, 32'h0002_0000, 4'hF, 2'h0);
        hic_link_partner_i.drive(7'b1100000);
        tick(2);
        chk("stop_hold", 1'b0, link_stop_allow);
        hic_link_partner_i.drive(7'b1000000);
        tick(2);
        chk("stop_free", 1'b1, link_stop_allow);
        rd(12'h0C0, 32'h0000_0002, 2'h0);
        wr(12'h08C, 32'h1000_0000, 4'hF, 2'h0);
        pulses(7'b0011000, 0, 0);
        pulses(7'b0001000, 1, 0);
        pulses(7'b0010000, 0, 0);
        pulses(7'b0000000, 0, 0);
        pulses(7'b0000100, 0, 1);
        wr(12'h05C, 32'h4000_0000, 4'hF, 2'h0);
        pulses(7'b0000010, 0, 0);
        chk("gsm_off", 1'b0, gsm_dma_detect);
        hic_link_partner_i.drive(7'b0000011);
        tick(2);
        chk("gsm_c3", 1'b1, gsm_dma_detect);
    endtask : t_link
    task automatic t_warm;
        wr(12'h170, 32'h0001_0008, 4'hF, 2'h0);
        tick(1);
        chk("clump_now", 3'h3, unit_id_clump);
        wr(12'h170, 32'hFFFF_FFFF, 4'hF, 2'h0);
        rd(12'h170, 32'h0005_0008, 2'h0);
        wr(12'h320, 32'h0000_1000, 4'hF, 2'h0);
        tick(1);
        chk("iso_wait", 1'b0, isochronous_flow_mode);
        chk("disp_ref_on", 1'b1, hic_link_partner_i.display_refresh_r);
        @(posedge aclk);
        warm_reset <= 1'b1;
        @(posedge aclk);
        warm_reset <= 1'b0;
        tick(1);
        chk("clump_clr", 3'h0, unit_id_clump);
        chk("iso_on", 1'b1, isochronous_flow_mode);
        chk("disp_ref_off", 1'b0, hic_link_partner_i.display_refresh_r);
        rd(12'h170, 32'h0000_0000, 2'h0);
        rd(12'h320, 32'h0000_1000, 2'h0);
        wr(12'h170, 32'h0004_0000, 4'hF, 2'h0);
        tick(1);
        chk("clump_again", 3'h4, unit_id_clump);
    endtask : t_warm
    task automatic wrap_up;
        if (num_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up
    // Whole run is well under two thousand cycles
    initial begin
        #20000;
        num_errors++;
        wrap_up();
    end
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_txn();
        t_misc();
        t_link();
        t_warm();
        wrap_up();
    end
endmodule : hic_link_config_tb
